// file: logic/conv_regs_cfg.svh
// Register map, field positions and reset values of the converter register bank
`ifndef CONV_REGS_CFG_SVH
`define CONV_REGS_CFG_SVH
`define ADDR_W 15
`define SAMPLE_W 14
`define THR_W 13
`define ADDR_REF_WINDOW 15'h128
`define ADDR_REF_PHASE 15'h129
`define ADDR_OP_MODE 15'h200
`define ADDR_DEC_RATIO 15'h201
`define ADDR_OFFSET_TRIM 15'h228
`define ADDR_OVR_CTRL 15'h245
`define ADDR_OVR_THR_LO 15'h247
`define ADDR_OVR_THR_HI 15'h248
`define MODE_QIGN_BIT 5
`define FDC_FORCE_BIT 3
`define FDC_VALUE_BIT 2
`define FDC_EN_BIT 0
`define RST_BYTE 8'h00
`define MODE_FULL 2'h0
`define MODE_DDC0 2'h1
`define MODE_DDC01 2'h2
`define MODE_DDC_ALL 2'h3
`define DDC_NONE 4'h0
`define DDC_ONE 4'h1
`define DDC_TWO 4'h3
`define DDC_FOUR 4'hf
`define DEC_BY1 3'h0
`define DEC_BY2 3'h1
`define DEC_BY4 3'h2
`define DEC_BY8 3'h3
`define HDR_LAST 5'h0f
`define HDR_BITS 5'h10
`define WR_LAST 5'h17
`define FRAME_BITS 5'h18
`endif

// file: logic/conv_regs_pkg.sv
// Types shared by the converter register bank and its serial control port
package conv_regs_pkg;
`include "conv_regs_cfg.svh"
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_HDR = 3'b010,
    PH_DATA = 3'b100
  } spi_phase_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic sdio_s1;
    logic sdio_s2;
    spi_phase_t phase;
    logic [4:0] cnt;
    logic [15:0] shreg;
    logic rd;
    logic loaded;
    logic [`ADDR_W-1:0] addr;
    logic [7:0] tx;
    logic wr;
    logic [7:0] wdata;
  } spi_state_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] ddc;
    logic qign;
    logic [2:0] ratio;
    logic [7:0] trim;
    logic fd_force;
    logic fd_val;
    logic fd_en;
    logic [`THR_W-1:0] thr;
    logic [3:0] div_phase;
    logic [2:0] dec_cnt;
    logic det;
    logic flag;
    logic out_valid;
    logic [`SAMPLE_W-1:0] out_i;
    logic [`SAMPLE_W-1:0] out_q;
  } bank_state_t;
endpackage : conv_regs_pkg

// file: logic/spi_port.sv
// Three-wire serial control port: 16-bit header then one data byte
`timescale 1ns/100ps
`include "conv_regs_cfg.svh"
module spi_port
  import conv_regs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  output logic [`ADDR_W-1:0] o_addr,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic [7:0] o_wdata
);
  spi_state_t st;
  spi_state_t next_st;
  logic rise;
  logic fall;

  // Edges seen on the system clock, so SCLK must stay below a quarter of it
  assign rise = st.sclk_s2 & ~st.sclk_d;
  assign fall = ~st.sclk_s2 & st.sclk_d;

  always_comb begin
    next_st = st;
    next_st.wr = 1'b0;
    next_st.cs_s1 = i_cs_n;
    next_st.cs_s2 = st.cs_s1;
    next_st.sclk_s1 = i_sclk;
    next_st.sclk_s2 = st.sclk_s1;
    next_st.sclk_d = st.sclk_s2;
    next_st.sdio_s1 = i_sdio;
    next_st.sdio_s2 = st.sdio_s1;
    if (st.cs_s2) begin
      next_st.phase = PH_IDLE;
      next_st.cnt = 5'h00;
      next_st.loaded = 1'b0;
      next_st.rd = 1'b0;
    end else begin
      case (st.phase)
        PH_IDLE, PH_HDR: begin
          next_st.phase = PH_HDR;
          if (rise) begin
            next_st.shreg = {st.shreg[14:0], st.sdio_s2};
            next_st.cnt = st.cnt + 5'h01;
            if (st.cnt == `HDR_LAST) begin
              next_st.phase = PH_DATA;
              next_st.rd = st.shreg[14];
              next_st.addr = {st.shreg[13:0], st.sdio_s2};
            end
          end
        end
        PH_DATA: begin
          if (!st.loaded) begin
            next_st.tx = i_rdata;
            next_st.loaded = 1'b1;
          end else if (fall && st.cnt > `HDR_BITS) begin
            next_st.tx = {st.tx[6:0], 1'b0};
          end
          if (rise && st.cnt < `FRAME_BITS) begin
            next_st.shreg = {st.shreg[14:0], st.sdio_s2};
            next_st.cnt = st.cnt + 5'h01;
            if (st.cnt == `WR_LAST && !st.rd) begin
              next_st.wr = 1'b1;
              next_st.wdata = {st.shreg[6:0], st.sdio_s2};
            end
          end
        end
        default: next_st.phase = PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{cs_s1: 1'b1, cs_s2: 1'b1, phase: PH_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign o_sdio = st.tx[7];
  assign o_sdio_oe = (st.phase == PH_DATA) && st.rd && !st.cs_s2;
  assign o_addr = st.addr;
  assign o_wr = st.wr;
  assign o_wdata = st.wdata;
endmodule : spi_port

// file: logic/conv_mode_detect_regs.sv
// Mode, decimation, offset trim and overrange detect register bank with sample path
`timescale 1ns/100ps
`include "conv_regs_cfg.svh"
module conv_mode_detect_regs
  import conv_regs_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_SPI_CS_N,
  input wire logic I_SPI_SCLK,
  input wire logic I_SPI_SDIO,
  output logic O_SPI_SDIO,
  output logic O_SPI_SDIO_OE,
  input wire logic [3:0] I_HOLD_STATUS,
  input wire logic [3:0] I_SETUP_STATUS,
  input wire logic [3:0] I_DIV_PHASE,
  input wire logic I_REF_CAPTURE,
  input wire logic I_SAMPLE_VALID,
  input wire logic [`SAMPLE_W-1:0] I_SAMPLE_I,
  input wire logic [`SAMPLE_W-1:0] I_SAMPLE_Q,
  output logic O_OUT_VALID,
  output logic [`SAMPLE_W-1:0] O_OUT_I,
  output logic [`SAMPLE_W-1:0] O_OUT_Q,
  output logic [3:0] O_DDC_ENABLE,
  output logic O_OVERRANGE_FLAG_OUT_FIRST,
  output logic O_OVERRANGE_FLAG_OUT_SECOND
);
  bank_state_t st;
  bank_state_t next_st;
  logic [`ADDR_W-1:0] addr;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [`SAMPLE_W-1:0] corr_i;
  logic [`SAMPLE_W-1:0] corr_q;
  logic [`SAMPLE_W-1:0] mag;
  logic [2:0] dec_mask;

  // Saturate rather than wrap so a trimmed full-scale sample stays full scale
  function automatic logic [`SAMPLE_W-1:0] trim_add(input logic [`SAMPLE_W-1:0] s, input logic [7:0] t);
    logic [`SAMPLE_W:0] sum;
    sum = {s[`SAMPLE_W-1], s} + {{(`SAMPLE_W-7){t[7]}}, t};
    if (sum[`SAMPLE_W] != sum[`SAMPLE_W-1]) begin
      trim_add = {sum[`SAMPLE_W], {(`SAMPLE_W-1){~sum[`SAMPLE_W]}}};
    end else begin
      trim_add = sum[`SAMPLE_W-1:0];
    end
  endfunction : trim_add

  spi_port u_spi_port (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .i_cs_n(I_SPI_CS_N),
    .i_sclk(I_SPI_SCLK),
    .i_sdio(I_SPI_SDIO),
    .o_sdio(O_SPI_SDIO),
    .o_sdio_oe(O_SPI_SDIO_OE),
    .o_addr(addr),
    .i_rdata(rdata),
    .o_wr(wr),
    .o_wdata(wdata)
  );

  always_comb begin
    if (addr == `ADDR_REF_WINDOW) begin
      rdata = {I_HOLD_STATUS, I_SETUP_STATUS};
    end else if (addr == `ADDR_REF_PHASE) begin
      rdata = {4'h0, st.div_phase};
    end else if (addr == `ADDR_OP_MODE) begin
      rdata = {2'h0, st.qign, 3'h0, st.mode};
    end else if (addr == `ADDR_DEC_RATIO) begin
      rdata = {5'h00, st.ratio};
    end else if (addr == `ADDR_OFFSET_TRIM) begin
      rdata = st.trim;
    end else if (addr == `ADDR_OVR_CTRL) begin
      rdata = {4'h0, st.fd_force, st.fd_val, 1'b0, st.fd_en};
    end else if (addr == `ADDR_OVR_THR_LO) begin
      rdata = st.thr[7:0];
    end else if (addr == `ADDR_OVR_THR_HI) begin
      rdata = {3'h0, st.thr[`THR_W-1:8]};
    end else begin
      rdata = 8'h00;
    end
  end

  assign corr_i = trim_add(I_SAMPLE_I, st.trim);
  assign corr_q = trim_add(I_SAMPLE_Q, st.trim);
  assign mag = corr_i[`SAMPLE_W-1] ? (~corr_i + 14'h0001) : corr_i;

  always_comb begin
    case (st.ratio)
      `DEC_BY2: dec_mask = 3'h1;
      `DEC_BY4: dec_mask = 3'h3;
      `DEC_BY8: dec_mask = 3'h7;
      default: dec_mask = 3'h0;
    endcase
  end

  always_comb begin
    next_st = st;
    // Status registers have no write path at all
    if (wr) begin
      if (addr == `ADDR_OP_MODE) begin
        next_st.mode = wdata[1:0];
        next_st.qign = wdata[`MODE_QIGN_BIT];
      end else if (addr == `ADDR_DEC_RATIO) begin
        next_st.ratio = wdata[2:0];
      end else if (addr == `ADDR_OFFSET_TRIM) begin
        next_st.trim = wdata;
      end else if (addr == `ADDR_OVR_CTRL) begin
        next_st.fd_force = wdata[`FDC_FORCE_BIT];
        next_st.fd_val = wdata[`FDC_VALUE_BIT];
        next_st.fd_en = wdata[`FDC_EN_BIT];
      end else if (addr == `ADDR_OVR_THR_LO) begin
        next_st.thr[7:0] = wdata;
      end else if (addr == `ADDR_OVR_THR_HI) begin
        next_st.thr[`THR_W-1:8] = wdata[4:0];
      end
    end
    case (next_st.mode)
      `MODE_DDC0: next_st.ddc = `DDC_ONE;
      `MODE_DDC01: next_st.ddc = `DDC_TWO;
      `MODE_DDC_ALL: next_st.ddc = `DDC_FOUR;
      default: next_st.ddc = `DDC_NONE;
    endcase
    if (I_REF_CAPTURE) begin
      next_st.div_phase = I_DIV_PHASE;
    end
    next_st.out_valid = 1'b0;
    if (I_SAMPLE_VALID) begin
      next_st.det = mag > {1'b0, st.thr};
      next_st.dec_cnt = (st.dec_cnt + 3'h1) & dec_mask;
      // Masked so a count left by a coarser ratio cannot drop samples
      if ((st.dec_cnt & dec_mask) == 3'h0) begin
        next_st.out_valid = 1'b1;
        next_st.out_i = corr_i;
        next_st.out_q = st.qign ? '0 : corr_q;
      end
    end
    if (!st.fd_en) begin
      next_st.flag = 1'b0;
    end else if (st.fd_force) begin
      next_st.flag = st.fd_val;
    end else begin
      next_st.flag = st.det;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign O_OUT_VALID = st.out_valid;
  assign O_OUT_I = st.out_i;
  assign O_OUT_Q = st.out_q;
  assign O_DDC_ENABLE = st.ddc;
  assign O_OVERRANGE_FLAG_OUT_FIRST = st.flag;
  assign O_OVERRANGE_FLAG_OUT_SECOND = st.flag;

  property p_ref_window;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (addr == `ADDR_REF_WINDOW) |-> (rdata == {I_HOLD_STATUS, I_SETUP_STATUS});
  endproperty
  a_ref_window: assert property (p_ref_window) else $error("window status read mismatch");

  property p_phase_capture;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      I_REF_CAPTURE |=> (st.div_phase == $past(I_DIV_PHASE)) && (rdata[7:4] == 4'h0 || addr != `ADDR_REF_PHASE);
  endproperty
  a_phase_capture: assert property (p_phase_capture) else $error("divider phase not captured");

  property p_mode_two;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (st.mode == `MODE_DDC01) |-> (O_DDC_ENABLE == `DDC_TWO);
  endproperty
  a_mode_two: assert property (p_mode_two) else $error("mode 10 must enable two downconverters");

  property p_qign;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (I_SAMPLE_VALID && st.qign && st.dec_cnt == 3'h0) |=> O_OUT_VALID && (O_OUT_Q == '0);
  endproperty
  a_qign: assert property (p_qign) else $error("quadrature not suppressed");

  property p_full_rate;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (st.ratio == `DEC_BY1 && I_SAMPLE_VALID) |=> O_OUT_VALID;
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("full rate dropped a sample");

  property p_force;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (st.fd_en && st.fd_force) |=> (O_OVERRANGE_FLAG_OUT_FIRST == $past(st.fd_val))
        && (O_OVERRANGE_FLAG_OUT_SECOND == $past(st.fd_val));
  endproperty
  a_force: assert property (p_force) else $error("forced flag value not driven");

  property p_normal;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (st.fd_en && !st.fd_force) |=> (O_OVERRANGE_FLAG_OUT_FIRST == $past(st.det));
  endproperty
  a_normal: assert property (p_normal) else $error("flag not following detector");

  property p_thr_hi;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (wr && addr == `ADDR_OVR_THR_HI) |=> (st.thr[`THR_W-1:8] == $past(wdata[4:0])) && (rdata[7:5] == 3'h0);
  endproperty
  a_thr_hi: assert property (p_thr_hi) else $error("threshold high byte wrong");

  property p_zero_trim;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (I_SAMPLE_VALID && st.trim == 8'h00 && st.dec_cnt == 3'h0) |=> (O_OUT_I == $past(I_SAMPLE_I));
  endproperty
  a_zero_trim: assert property (p_zero_trim) else $error("zero trim altered sample");

  property p_disabled;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      !st.fd_en |=> !O_OVERRANGE_FLAG_OUT_FIRST && !O_OVERRANGE_FLAG_OUT_SECOND;
  endproperty
  a_disabled: assert property (p_disabled) else $error("flag driven while disabled");
endmodule : conv_mode_detect_regs

// file: dv/conv_mode_detect_regs_tb.sv
// Self-checking bench for the converter mode and overrange detect register bank
`timescale 1ns/100ps
`include "conv_regs_cfg.svh"
module conv_mode_detect_regs_tb;
  import conv_regs_pkg::*;
  logic clk, rst_n, cs_n, sclk, sdio_drv, s_valid, ref_cap;
  logic [3:0] hold_st, setup_st, div_ph;
  logic [`SAMPLE_W-1:0] s_i, s_q;
  logic sdio_o, sdio_oe, o_valid, flag_a, flag_b;
  logic [`SAMPLE_W-1:0] o_i, o_q;
  logic [3:0] ddc;
  int mismatches = 0;
  int compares = 0;
  // Shared data wire: device wins while it drives
  wire sdio_w = sdio_oe ? sdio_o : sdio_drv;

  conv_mode_detect_regs uut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_SPI_CS_N(cs_n), .I_SPI_SCLK(sclk),
    .I_SPI_SDIO(sdio_w), .O_SPI_SDIO(sdio_o), .O_SPI_SDIO_OE(sdio_oe), .I_HOLD_STATUS(hold_st),
    .I_SETUP_STATUS(setup_st), .I_DIV_PHASE(div_ph), .I_REF_CAPTURE(ref_cap), .I_SAMPLE_VALID(s_valid),
    .I_SAMPLE_I(s_i), .I_SAMPLE_Q(s_q), .O_OUT_VALID(o_valid), .O_OUT_I(o_i), .O_OUT_Q(o_q),
    .O_DDC_ENABLE(ddc), .O_OVERRANGE_FLAG_OUT_FIRST(flag_a), .O_OVERRANGE_FLAG_OUT_SECOND(flag_b));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic summarize();
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Slow serial clock: five system clocks low and six high per bit keeps the synchroniser happy
  task automatic spi(input logic rw, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] f;
    f = {rw, a, wd};
    rd = 8'h00;
    @(negedge clk) cs_n = 1'b0;
    for (int k = 0; k < 24; k++) begin
      @(negedge clk);
      sclk = 1'b0;
      sdio_drv = f[23-k];
      repeat (5) @(negedge clk);
      sclk = 1'b1;
      repeat (5) @(negedge clk);
      if (k >= 16) rd[23-k] = sdio_w;
      if (k == 16) chk({15'h0000, sdio_oe}, {15'h0000, rw});
    end
    repeat (8) @(negedge clk);
    sclk = 1'b0;
    cs_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask : spi

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] r;
    spi(1'b0, a, d, r);
  endtask : wr

  task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] r;
    // Bench drives the inverse, so a silent device cannot pass
    spi(1'b1, a, ~exp, r);
    chk({8'h00, r}, {8'h00, exp});
  endtask : rdchk

  // One sample in, then the registered result after a bounded wait
  task automatic sample(input logic [13:0] i, input logic [13:0] q);
    int n;
    @(negedge clk);
    s_i = i;
    s_q = q;
    s_valid = 1'b1;
    @(negedge clk) s_valid = 1'b0;
    n = 0;
    while (o_valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (n >= 4) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, o_valid, 1'b1);
      summarize();
    end
    repeat (3) @(negedge clk);
  endtask : sample

  task automatic t_reset_vals();
    rdchk(`ADDR_OP_MODE, 8'h00);
    rdchk(`ADDR_DEC_RATIO, 8'h00);
    rdchk(`ADDR_OFFSET_TRIM, 8'h00);
    rdchk(`ADDR_OVR_CTRL, 8'h00);
    rdchk(`ADDR_OVR_THR_LO, 8'h00);
    chk({12'h000, ddc}, 16'h0000);
    chk({15'h0000, flag_a}, 16'h0000);
  endtask : t_reset_vals

  task automatic t_status();
    hold_st = 4'ha;
    setup_st = 4'h5;
    rdchk(`ADDR_REF_WINDOW, 8'ha5);
    wr(`ADDR_REF_WINDOW, 8'hff);
    rdchk(`ADDR_REF_WINDOW, 8'ha5);
    @(negedge clk);
    div_ph = 4'h4;
    ref_cap = 1'b1;
    @(negedge clk);
    ref_cap = 1'b0;
    div_ph = 4'h2;
    rdchk(`ADDR_REF_PHASE, 8'h04);
    wr(`ADDR_REF_PHASE, 8'h0f);
    rdchk(`ADDR_REF_PHASE, 8'h04);
    rdchk(15'h300, 8'h00);
  endtask : t_status

  task automatic t_modes();
    logic [3:0] exp[4] = '{`DDC_NONE, `DDC_ONE, `DDC_TWO, `DDC_FOUR};
    for (int m = 0; m < 4; m++) begin
      wr(`ADDR_OP_MODE, {6'h00, m[1:0]});
      chk({12'h000, ddc}, {12'h000, exp[m]});
      rdchk(`ADDR_OP_MODE, {6'h00, m[1:0]});
    end
    wr(`ADDR_OP_MODE, 8'h00);
  endtask : t_modes

  // Sixteen back-to-back samples; output count shows the kept fraction
  task automatic t_decim();
    int cnt;
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_DEC_RATIO, {5'h00, c[2:0]});
      cnt = 0;
      for (int k = 0; k < 20; k++) begin
        @(negedge clk);
        s_valid = (k < 16);
        if (o_valid === 1'b1) cnt++;
      end
      chk(cnt[15:0], 16'(16 >> c));
    end
    // Leave the divider mid-count, then full rate must keep every sample
    @(negedge clk) s_valid = 1'b1;
    repeat (3) @(negedge clk);
    s_valid = 1'b0;
    wr(`ADDR_DEC_RATIO, 8'h00);
    cnt = 0;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      s_valid = (k < 4);
      if (o_valid === 1'b1) cnt++;
    end
    chk(cnt[15:0], 16'h0004);
  endtask : t_decim

  task automatic t_trim_q();
    wr(`ADDR_OFFSET_TRIM, 8'hff);
    sample(14'h0005, 14'h0007);
    chk({2'h0, o_i}, 16'h0004);
    chk({2'h0, o_q}, 16'h0006);
    wr(`ADDR_OP_MODE, 8'h20);
    rdchk(`ADDR_OP_MODE, 8'h20);
    sample(14'h0005, 14'h0007);
    chk({2'h0, o_i}, 16'h0004);
    chk({2'h0, o_q}, 16'h0000);
    wr(`ADDR_OP_MODE, 8'h00);
    wr(`ADDR_OFFSET_TRIM, 8'h00);
  endtask : t_trim_q

  task automatic t_detect();
    wr(`ADDR_OVR_THR_LO, 8'h34);
    wr(`ADDR_OVR_THR_HI, 8'he1);
    rdchk(`ADDR_OVR_THR_HI, 8'h01);
    rdchk(`ADDR_OVR_THR_LO, 8'h34);
    wr(`ADDR_OVR_CTRL, 8'h0c);
    chk({14'h0000, flag_a, flag_b}, 16'h0000);
    wr(`ADDR_OVR_CTRL, 8'h0d);
    chk({14'h0000, flag_a, flag_b}, 16'h0003);
    wr(`ADDR_OVR_CTRL, 8'h09);
    chk({14'h0000, flag_a, flag_b}, 16'h0000);
    // Force clear with value set: detector result must win
    wr(`ADDR_OVR_CTRL, 8'h05);
    sample(14'd400, 14'h0000);
    chk({14'h0000, flag_a, flag_b}, 16'h0003);
    sample(14'd308, 14'h0000);
    chk({14'h0000, flag_a, flag_b}, 16'h0000);
    sample(14'd309, 14'h0000);
    chk({14'h0000, flag_a, flag_b}, 16'h0003);
    wr(`ADDR_OVR_CTRL, 8'h04);
    chk({14'h0000, flag_a, flag_b}, 16'h0000);
  endtask : t_detect

  initial begin
    rst_n = 1'b0;
    cs_n = 1'b1;
    sclk = 1'b0;
    sdio_drv = 1'b0;
    s_valid = 1'b0;
    ref_cap = 1'b0;
    hold_st = 4'h0;
    setup_st = 4'h0;
    div_ph = 4'h0;
    s_i = '0;
    s_q = '0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset_vals();
    t_status();
    t_modes();
    t_decim();
    t_trim_q();
    t_detect();
    summarize();
  end
endmodule : conv_mode_detect_regs_tb
